// *** core/nfss_pkg.sv ***
// Package for the fix sentence stream framer.
// Assumes a single 25 MHz clock domain and fixed-width ASCII fields from the user.
package nfss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ             = 25_000_000;
  localparam int unsigned BAUD_DEFAULT       = 4800;
  localparam int unsigned BIT_CYCLES_DEFAULT = CLK_HZ / BAUD_DEFAULT;

  // ----------------------------------------------------------------
  // Sentence image
  // ----------------------------------------------------------------
  localparam int unsigned SENT_MAX = 70;
  localparam int unsigned GGA_LEN  = 70;
  localparam int unsigned GLL_LEN  = 43;
  localparam int unsigned GSA_LEN  = 57;
  localparam int unsigned SV_SLOTS = 12;

  localparam logic [47:0] HDR_GGA  = 48'h4750_4747_412C;
  localparam logic [47:0] HDR_GLL  = 48'h4750_474C_4C2C;
  localparam logic [47:0] HDR_GSA  = 48'h4750_4753_412C;
  localparam logic [47:0] GGA_UNIT = 48'h2C4D_2C2C_4D2C;

  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_STAR   = 8'h2A;
  localparam logic [7:0] CH_COMMA  = 8'h2C;
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_LF     = 8'h0A;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_HEX_AF = 8'h37;
  localparam logic [7:0] CH_A      = 8'h41;
  localparam logic [7:0] CH_M      = 8'h4D;
  localparam logic [7:0] CH_V      = 8'h56;
  localparam logic [7:0] CH_SKIP   = 8'h00;
  localparam logic [3:0] HEX_TEN   = 4'hA;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NFSS_GGA,
    NFSS_GLL,
    NFSS_GSA
  } nfss_kind_t;

  typedef struct packed {
    logic [9:0][7:0]         utc_time;
    logic [8:0][7:0]         latitude;
    logic [7:0]              north_south;
    logic [9:0][7:0]         longitude;
    logic [7:0]              east_west;
    logic [1:0]              fix_indicator;
    logic [1:0][7:0]         sats_used;
    logic [2:0][7:0]         hdop;
    logic [4:0][7:0]         altitude;
    logic                    dgps_used;
    logic [2:0][7:0]         corr_age;
    logic [3:0][7:0]         station_id;
    logic                    data_valid;
    logic                    mode_manual;
    logic [1:0]              fix_mode;
    logic [0:11][1:0][7:0]   sv_id;
    logic [0:11]             sv_used;
    logic [2:0][7:0]         pdop;
    logic [2:0][7:0]         vdop;
  } nfss_fix_t;

endpackage : nfss_pkg

// *** core/nfss_uart_tx.sv ***
// Serial transmitter, 8 data bits, no parity, one stop bit, LSB first.
// Assumes send is only raised while ready is high; reset is already synchronised.
`timescale 1ns/1ps
module nfss_uart_tx
  import nfss_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEFAULT
) (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Byte request
  input  wire logic       send,
  input  wire logic [7:0] data,
  output logic            ready,
  // Line
  output logic            txd
);

  localparam int unsigned CNT_W = $clog2(BIT_CYCLES);

  if (BIT_CYCLES < 2) begin : g_bad_bit_cycles
    $error("BIT_CYCLES must be at least 2");
  end

  logic [9:0]       shift_reg,  shift_next;
  logic [3:0]       bits_reg,   bits_next;
  logic [CNT_W-1:0] cnt_reg,    cnt_next;
  logic             ready_reg,  ready_next;
  logic             txd_reg,    txd_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    shift_next = shift_reg;
    bits_next  = bits_reg;
    cnt_next   = cnt_reg;
    ready_next = ready_reg;
    txd_next   = txd_reg;
    if (ready_reg) begin
      if (send) begin
        shift_next = {1'b1, data, 1'b0};
        bits_next  = 4'd10;
        cnt_next   = CNT_W'(BIT_CYCLES - 1);
        ready_next = 1'b0;
        txd_next   = 1'b0;
      end
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end else if (bits_reg == 4'd1) begin
      ready_next = 1'b1;
      txd_next   = 1'b1;
      bits_next  = 4'd0;
    end else begin
      shift_next = {1'b1, shift_reg[9:1]};
      txd_next   = shift_reg[1];
      bits_next  = bits_reg - 4'd1;
      cnt_next   = CNT_W'(BIT_CYCLES - 1);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '1;
      bits_reg  <= '0;
      cnt_reg   <= '0;
      ready_reg <= 1'b1;
      txd_reg   <= 1'b1;
    end else if (ce) begin
      shift_reg <= shift_next;
      bits_reg  <= bits_next;
      cnt_reg   <= cnt_next;
      ready_reg <= ready_next;
      txd_reg   <= txd_next;
    end
  end

  assign ready = ready_reg;
  assign txd   = txd_reg;

endmodule : nfss_uart_tx

// *** core/nfss_framer.sv ***
// Fix sentence stream framer: emits GGA, GLL and GSA sentences on the primary
// serial line from one captured fix snapshot.
// Assumes the host supplies reset and strap levels and parses the stream.
//
// Notes on behaviour
// - Output on primary out, commands only on primary in.
// - Secondary serial lines carry no traffic.
// - Fix data sentence fields in fixed order.
// - Fix indicator digit 0 to 3.
// - Correction age empty without differential use.
// - Geoid separation field always empty.
// - Position sentence fields in fixed order.
// - Status letter A valid, V invalid.
// - Dilution sentence: modes, twelve slots, three DOPs.
// - Star, checksum, CR LF end every sentence.
// - XOR between dollar and star, two hex.
// - Mode 1 letter M manual, A automatic.
// - Mode 2 digit 1 none, 2D, 3D.
`timescale 1ns/1ps
module nfss_framer
  import nfss_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEFAULT
) (
  // Clock, reset and enable
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire logic      ce,
  // Fix snapshot request
  input  wire logic      fix_start,
  input  wire nfss_fix_t fix_data,
  output logic           busy,
  // Pins
  input  wire logic      flash_program_select,
  input  wire logic      primary_serial_in,
  output logic           primary_serial_out,
  output logic           secondary_serial_out,
  output logic           cmd_rx_level
);

  typedef enum {
    ST_IDLE,
    ST_DOLLAR,
    ST_BODY,
    ST_STAR,
    ST_HEX_HI,
    ST_HEX_LO,
    ST_CR,
    ST_LF
  } nfss_state_t;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [1:0] prog_sync_reg;
  logic [1:0] rx_sync_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_sync_reg <= 2'b00;
      rx_sync_reg   <= 2'b11;
    end else if (ce) begin
      prog_sync_reg <= {prog_sync_reg[0], flash_program_select};
      rx_sync_reg   <= {rx_sync_reg[0], primary_serial_in};
    end
  end

  // ----------------------------------------------------------------
  // Sentence images
  // ----------------------------------------------------------------
  nfss_state_t              state_reg, state_next;
  nfss_kind_t               kind_reg,  kind_next;
  nfss_fix_t                snap_reg,  snap_next;
  logic [6:0]               idx_reg,   idx_next;
  logic [7:0]               csum_reg,  csum_next;
  logic                     busy_reg,  busy_next;
  logic                     rxl_reg;
  logic [SENT_MAX*8-1:0]    img;
  logic [GGA_LEN*8-1:0]     gga_v;
  logic [GLL_LEN*8-1:0]     gll_v;
  logic [GSA_LEN*8-1:0]     gsa_v;
  logic [0:11][23:0]        slots;
  logic [7:0]               cur;
  logic [7:0]               status_ch;
  logic                     send;
  logic [7:0]               tx_byte;
  logic                     tx_ready;

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < HEX_TEN) ? (CH_ZERO + {4'h0, n}) : (CH_HEX_AF + {4'h0, n});
  endfunction : hex_ch

  always_comb begin
    for (int i = 0; i < SV_SLOTS; i++) begin
      slots[i] = {(snap_reg.sv_used[i] ? snap_reg.sv_id[i] : 16'h0000), CH_COMMA};
    end
    status_ch = snap_reg.data_valid ? CH_A : CH_V;
    gga_v = {HDR_GGA, snap_reg.utc_time, CH_COMMA, snap_reg.latitude, CH_COMMA,
             snap_reg.north_south, CH_COMMA, snap_reg.longitude, CH_COMMA,
             snap_reg.east_west, CH_COMMA,
             CH_ZERO + {6'h00, snap_reg.fix_indicator}, CH_COMMA,
             snap_reg.sats_used, CH_COMMA, snap_reg.hdop, CH_COMMA,
             snap_reg.altitude, GGA_UNIT,
             (snap_reg.dgps_used ? snap_reg.corr_age : 24'h00_0000),
             CH_COMMA, snap_reg.station_id};
    gll_v = {HDR_GLL, snap_reg.latitude, CH_COMMA, snap_reg.north_south, CH_COMMA,
             snap_reg.longitude, CH_COMMA, snap_reg.east_west, CH_COMMA,
             snap_reg.utc_time, CH_COMMA, status_ch};
    gsa_v = {HDR_GSA, (snap_reg.mode_manual ? CH_M : CH_A), CH_COMMA,
             CH_ZERO + {6'h00, snap_reg.fix_mode}, CH_COMMA,
             slots, snap_reg.pdop, CH_COMMA, snap_reg.hdop, CH_COMMA,
             snap_reg.vdop};
    case (kind_reg)
      NFSS_GGA: img = gga_v;
      NFSS_GLL: img = {gll_v, {((SENT_MAX - GLL_LEN) * 8){1'b0}}};
      NFSS_GSA: img = {gsa_v, {((SENT_MAX - GSA_LEN) * 8){1'b0}}};
      default:  img = '0;
    endcase
    cur = img[(SENT_MAX - 1 - 32'(idx_reg)) * 8 +: 8];
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    kind_next  = kind_reg;
    snap_next  = snap_reg;
    idx_next   = idx_reg;
    csum_next  = csum_reg;
    send       = 1'b0;
    tx_byte    = CH_SKIP;
    case (state_reg)
      ST_IDLE: begin
        if (fix_start && !prog_sync_reg[1]) begin
          snap_next  = fix_data;
          kind_next  = NFSS_GGA;
          state_next = ST_DOLLAR;
        end
      end
      ST_DOLLAR: begin
        if (tx_ready) begin
          send       = 1'b1;
          tx_byte    = CH_DOLLAR;
          csum_next  = 8'h00;
          idx_next   = 7'd0;
          state_next = ST_BODY;
        end
      end
      ST_BODY: begin
        if (idx_reg == 7'(SENT_MAX)) begin
          state_next = ST_STAR;
        end else if (cur == CH_SKIP) begin
          idx_next = idx_reg + 7'd1;
        end else if (tx_ready) begin
          send      = 1'b1;
          tx_byte   = cur;
          csum_next = csum_reg ^ cur;
          idx_next  = idx_reg + 7'd1;
        end
      end
      ST_STAR: begin
        if (tx_ready) begin
          send       = 1'b1;
          tx_byte    = CH_STAR;
          state_next = ST_HEX_HI;
        end
      end
      ST_HEX_HI: begin
        if (tx_ready) begin
          send       = 1'b1;
          tx_byte    = hex_ch(csum_reg[7:4]);
          state_next = ST_HEX_LO;
        end
      end
      ST_HEX_LO: begin
        if (tx_ready) begin
          send       = 1'b1;
          tx_byte    = hex_ch(csum_reg[3:0]);
          state_next = ST_CR;
        end
      end
      ST_CR: begin
        if (tx_ready) begin
          send       = 1'b1;
          tx_byte    = CH_CR;
          state_next = ST_LF;
        end
      end
      ST_LF: begin
        if (tx_ready) begin
          send    = 1'b1;
          tx_byte = CH_LF;
          if (kind_reg == NFSS_GSA) begin
            state_next = ST_IDLE;
          end else begin
            kind_next  = (kind_reg == NFSS_GGA) ? NFSS_GLL : NFSS_GSA;
            state_next = ST_DOLLAR;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    busy_next = (state_next != ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      kind_reg  <= NFSS_GGA;
      snap_reg  <= '0;
      idx_reg   <= '0;
      csum_reg  <= '0;
      busy_reg  <= 1'b0;
      rxl_reg   <= 1'b1;
    end else if (ce) begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      snap_reg  <= snap_next;
      idx_reg   <= idx_next;
      csum_reg  <= csum_next;
      busy_reg  <= busy_next;
      rxl_reg   <= rx_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // Serial lines
  // ----------------------------------------------------------------
  nfss_uart_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .send  (send),
    .data  (tx_byte),
    .ready (tx_ready),
    .txd   (primary_serial_out)
  );

  logic sec_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_reg <= 1'b1;
    end else if (ce) begin
      sec_reg <= 1'b1;
    end
  end

  assign secondary_serial_out = sec_reg;
  assign busy                 = busy_reg;
  assign cmd_rx_level         = rxl_reg;

endmodule : nfss_framer

// *** sim/nfss_framer_properties.sv ***
// Checker for the fix sentence framer, watching only its top-level ports.
// Assumes ce is held high and the bench keeps the program select low while bursts run.
`timescale 1ns/1ps
module nfss_framer_properties
  import nfss_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic      clk,
  input wire logic      rst_b,
  input wire logic      ce,
  // Request
  input wire logic      fix_start,
  input wire nfss_fix_t fix_data,
  input wire logic      busy,
  // Pins
  input wire logic      flash_program_select,
  input wire logic      primary_serial_in,
  input wire logic      primary_serial_out,
  input wire logic      secondary_serial_out,
  input wire logic      cmd_rx_level
);
  localparam int LOW_MAX   = 9 * BIT_CYCLES;
  localparam int TAIL_SPAN = 11 * BIT_CYCLES + 8;
  logic [15:0] low_reg;
  logic [15:0] low_next;
  logic [15:0] quiet_reg;
  logic [15:0] quiet_next;
  logic [2:0]  up_reg;
  logic [2:0]  up_next;
  logic [16:0] rise_reg;
  logic [16:0] rise_next;
  logic        busy_d_reg;
  logic        busy_d_next;

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  always_comb begin
    low_next   = primary_serial_out ? 16'h0000 : low_reg + 16'h0001;
    quiet_next = busy ? 16'h0000 : ((&quiet_reg) ? quiet_reg : quiet_reg + 16'h0001);
    up_next    = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
    rise_next  = (!primary_serial_out || !(busy && (!busy_d_reg || rise_reg != 17'h0_0000)))
                 ? 17'h0_0000 : ((&rise_reg) ? rise_reg : rise_reg + 17'h0_0001);
    busy_d_next = busy;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_reg   <= 16'h0000;
      quiet_reg <= 16'h0000;
      up_reg    <= 3'h0;
      rise_reg  <= 17'h0_0000;
      busy_d_reg <= 1'b0;
    end else begin
      rise_reg  <= rise_next;
      busy_d_reg <= busy_d_next;
      low_reg   <= low_next;
      quiet_reg <= quiet_next;
      up_reg    <= up_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_SEC_IDLE: assert property (secondary_serial_out == 1'b1)
    else $error("secondary line left idle level");
  AST_CMD_ECHO: assert property ((up_reg == 3'h7) |->
    cmd_rx_level == $past(primary_serial_in, 3)) else $error("command level not echoed");
  AST_PROG_BLOCK: assert property (
    ((up_reg == 3'h7) && flash_program_select) [*4] ##0 !busy |=> !busy)
    else $error("burst started in program mode");
  AST_START_SOON: assert property (rise_reg <= TAIL_SPAN)
    else $error("no start bit after burst start");
  AST_BUSY_MIN: assert property ($rose(busy) |-> busy [*8])
    else $error("busy dropped too early");
  AST_LOW_RUN: assert property (low_reg <= LOW_MAX)
    else $error("line low longer than a byte");
  AST_BIT_CELL: assert property ($rose(primary_serial_out) |-> (low_reg % BIT_CYCLES) == 0)
    else $error("low run not whole bit cells");
  AST_IDLE_QUIET: assert property ($fell(primary_serial_out) |-> busy || quiet_reg < TAIL_SPAN)
    else $error("line activity while idle");
endmodule : nfss_framer_properties

bind nfss_framer nfss_framer_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (
  .clk(clk), .rst_b(rst_b), .ce(ce), .fix_start(fix_start), .fix_data(fix_data),
  .busy(busy), .flash_program_select(flash_program_select),
  .primary_serial_in(primary_serial_in), .primary_serial_out(primary_serial_out),
  .secondary_serial_out(secondary_serial_out), .cmd_rx_level(cmd_rx_level)
);

// *** sim/nfss_host_rx.sv ***
// Host receiver model: samples the serial line mid-cell, 8N1, LSB first.
// Assumes the line idles high; a byte with a bad stop bit is not handed on.
`timescale 1ns/1ps
module nfss_host_rx
  import nfss_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = 4
) (
  // Clock and line
  input  wire logic       clk,
  input  wire logic       line,
  // Received byte, one-cycle pulse
  output logic            got,
  output logic [7:0]      data,
  // Sentence result, one-cycle pulse after LF
  output logic            sent_done,
  output logic            sent_ok,
  output logic [7:0]      sent_fields
);
  int         cnt  = 0;
  int         bitn = -1;
  logic [7:0] sh   = 8'h00;
  initial got = 1'b0;
  initial data = 8'h00;
  int         phase = 0;
  logic [7:0] psum  = 8'h00;
  logic [7:0] rsum  = 8'h00;
  logic [7:0] nfld  = 8'h00;
  initial sent_done = 1'b0;
  initial sent_ok = 1'b0;
  initial sent_fields = 8'h00;
  always @(posedge clk) begin
    got <= 1'b0;
    if (bitn < 0) begin
      if (line === 1'b0) begin
        bitn <= 0;
        cnt  <= int'(BIT_CYCLES / 2) - 1;
      end
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else begin
      cnt  <= int'(BIT_CYCLES) - 1;
      bitn <= (bitn == 9) ? -1 : bitn + 1;
      if (bitn == 0 && line !== 1'b0) bitn <= -1;
      if (bitn >= 1 && bitn <= 8) sh <= {line, sh[7:1]};
      if (bitn == 9) begin
        got  <= (line === 1'b1);
        data <= sh;
      end
    end
  end
  // Sentence parser: a bad sum marks the sentence refused, commas count fields
  always @(posedge clk) begin
    sent_done <= 1'b0;
    if (got) begin
      if (data == CH_DOLLAR) begin
        phase <= 1;
        psum  <= 8'h00;
        nfld  <= 8'h01;
      end else if (phase == 1 && data == CH_STAR) begin
        phase <= 2;
      end else if (phase == 1) begin
        psum <= psum ^ data;
        if (data == CH_COMMA) nfld <= nfld + 8'h01;
      end else if (phase == 2 || phase == 3) begin
        rsum  <= {rsum[3:0], 4'(data - ((data < CH_A) ? CH_ZERO : CH_HEX_AF))};
        phase <= phase + 1;
      end else if (phase == 4 && data == CH_LF) begin
        sent_done   <= 1'b1;
        sent_ok     <= (rsum == psum);
        sent_fields <= nfld;
        phase       <= 0;
      end
    end
  end
endmodule : nfss_host_rx

// *** sim/nfss_framer_bench.sv ***
// Self-checking bench: builds each expected sentence byte by byte, compares host bytes.
// Assumes a shortened bit time and ce held high.
`timescale 1ns/1ps
module nfss_framer_bench;
  import nfss_pkg::*;
  localparam int unsigned BC = 4;
  logic       clk                  = 1'b0;
  logic       rst_b                = 1'b0;
  logic       fix_start            = 1'b0;
  logic       flash_program_select = 1'b0;
  logic       primary_serial_in    = 1'b1;
  nfss_fix_t  fix_data             = '0;
  logic       busy;
  logic       primary_serial_out;
  logic       secondary_serial_out;
  logic       cmd_rx_level;
  logic       got;
  logic [7:0] rx_b;
  logic [7:0] exp_q[$];
  logic [7:0] fld_q[$];
  logic       sent_done;
  logic       sent_ok;
  logic [7:0] sent_fields;
  logic [7:0] sum                  = 8'h00;
  logic       in_sum               = 1'b0;
  int         bad_count            = 0;
  int         n_checks             = 0;

  always #20 clk = ~clk;

  nfss_framer #(.BIT_CYCLES(BC)) dut (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .fix_start(fix_start), .fix_data(fix_data),
    .busy(busy), .flash_program_select(flash_program_select),
    .primary_serial_in(primary_serial_in), .primary_serial_out(primary_serial_out),
    .secondary_serial_out(secondary_serial_out), .cmd_rx_level(cmd_rx_level)
  );
  nfss_host_rx #(.BIT_CYCLES(BC)) host (.clk(clk), .line(primary_serial_out), .got(got),
    .data(rx_b), .sent_done(sent_done), .sent_ok(sent_ok), .sent_fields(sent_fields));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got_v, input logic [7:0] exp_v);
    n_checks++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask : chk8
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step
  task automatic put(input logic [7:0] b);
    if (b == CH_STAR) in_sum = 1'b0;
    if (in_sum) sum ^= b;
    if (b == CH_DOLLAR) begin
      in_sum = 1'b1;
      sum    = 8'h00;
    end
    exp_q.push_back(b);
  endtask : put
  task automatic fld(input logic [79:0] v, input int n, input logic comma);
    for (int i = n - 1; i >= 0; i--) if (v[i*8+:8] != CH_SKIP) put(v[i*8+:8]);
    if (comma) put(CH_COMMA);
  endtask : fld
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < HEX_TEN) ? CH_ZERO + {4'h0, n} : CH_HEX_AF + {4'h0, n};
  endfunction : hx
  task automatic tail;
    put(CH_STAR);
    put(hx(sum[7:4]));
    put(hx(sum[3:0]));
    put(CH_CR);
    put(CH_LF);
  endtask : tail
  function automatic logic [79:0] rd();
    logic [79:0] v;
    for (int i = 0; i < 10; i++) v[i*8+:8] = ($urandom % 8 == 0) ? CH_SKIP : CH_ZERO + 8'($urandom % 10);
    return v;
  endfunction : rd
  task automatic fill(input int k);
    fix_data.utc_time      = rd();
    fix_data.latitude      = 72'(rd());
    fix_data.north_south   = 8'(rd());
    fix_data.longitude     = rd();
    fix_data.east_west     = 8'(rd());
    fix_data.sats_used     = 16'(rd());
    fix_data.hdop          = 24'(rd());
    fix_data.altitude      = 40'(rd());
    fix_data.corr_age      = 24'(rd());
    fix_data.station_id    = 32'(rd());
    fix_data.pdop          = 24'(rd());
    fix_data.vdop          = 24'(rd());
    for (int i = 0; i < 12; i++) fix_data.sv_id[i] = 16'(rd());
    fix_data.sv_used       = 12'($urandom);
    fix_data.fix_indicator = 2'(k);
    fix_data.fix_mode      = 2'(k % 3 + 1);
    fix_data.dgps_used     = k[1] ^ k[0];
    fix_data.data_valid    = k[1];
    fix_data.mode_manual   = k[0];
  endtask : fill
  task automatic expect_burst;
    put(CH_DOLLAR);
    fld(HDR_GGA, 6, 1'b0);
    fld(fix_data.utc_time, 10, 1'b1);
    fld(fix_data.latitude, 9, 1'b1);
    fld(fix_data.north_south, 1, 1'b1);
    fld(fix_data.longitude, 10, 1'b1);
    fld(fix_data.east_west, 1, 1'b1);
    fld(CH_ZERO + {6'h00, fix_data.fix_indicator}, 1, 1'b1);
    fld(fix_data.sats_used, 2, 1'b1);
    fld(fix_data.hdop, 3, 1'b1);
    fld(fix_data.altitude, 5, 1'b0);
    fld(GGA_UNIT, 6, 1'b0);
    if (fix_data.dgps_used) fld(fix_data.corr_age, 3, 1'b0);
    put(CH_COMMA);
    fld(fix_data.station_id, 4, 1'b0);
    tail;
    fld_q.push_back(8'h8F);
    put(CH_DOLLAR);
    fld(HDR_GLL, 6, 1'b0);
    fld(fix_data.latitude, 9, 1'b1);
    fld(fix_data.north_south, 1, 1'b1);
    fld(fix_data.longitude, 10, 1'b1);
    fld(fix_data.east_west, 1, 1'b1);
    fld(fix_data.utc_time, 10, 1'b1);
    put(fix_data.data_valid ? CH_A : CH_V);
    tail;
    fld_q.push_back(8'h87);
    put(CH_DOLLAR);
    fld(HDR_GSA, 6, 1'b0);
    fld(fix_data.mode_manual ? CH_M : CH_A, 1, 1'b1);
    fld(CH_ZERO + {6'h00, fix_data.fix_mode}, 1, 1'b1);
    for (int i = 0; i < 12; i++) fld(fix_data.sv_used[i] ? fix_data.sv_id[i] : 16'h0000, 2, 1'b1);
    fld(fix_data.pdop, 3, 1'b1);
    fld(fix_data.hdop, 3, 1'b1);
    fld(fix_data.vdop, 3, 1'b0);
    tail;
    fld_q.push_back(8'h92);
  endtask : expect_burst
  task automatic wait_idle;
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) step(1);
    for (int i = 0; i < 200 && exp_q.size() + fld_q.size() != 0; i++) step(1);
    chk8(8'(exp_q.size() + fld_q.size()), 8'h00);
  endtask : wait_idle

  // ----------------------------------------------------------------
  // Monitor, main sequence, watchdog
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (got) chk8(rx_b, exp_q.size() != 0 ? exp_q.pop_front() : ~rx_b);
    if (sent_done) chk8({sent_ok, sent_fields[6:0]}, fld_q.size() != 0 ? fld_q.pop_front() : 8'h00);
  end
  initial begin
    void'($urandom(1104));
    step(6);
    chk8({4'h0, busy, primary_serial_out, secondary_serial_out, cmd_rx_level}, 8'h07);
    step(6);
    rst_b = 1'b1;
    step(3);
    for (int k = 0; k < 4; k++) begin
      fill(k);
      expect_burst;
      fix_start = 1'b1;
      step(1);
      chk8({7'h00, busy}, 8'h01);
      fill(3 - k);
      step(4);
      fix_start = 1'b0;
      wait_idle;
      primary_serial_in = 1'($urandom);
      step(3);
      chk8({7'h00, cmd_rx_level}, {7'h00, primary_serial_in});
    end
    flash_program_select = 1'b1;
    step(4);
    fix_start = 1'b1;
    step(3);
    chk8({7'h00, busy}, 8'h00);
    fix_start = 1'b0;
    flash_program_select = 1'b0;
    chk8({7'h00, secondary_serial_out}, 8'h01);
    wrap_up;
  end
  initial begin
    #(40 * 90000);
    bad_count++;
    wrap_up;
  end
endmodule : nfss_framer_bench
